// ===== core/adc_params.svh
// timing counts, pin positions and reset values of the converter result interface
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
`define WORD_W 16
`define CLK_PERIOD_NS 25
`define T_CONV_NS 1300
`define CONV_CYC (`T_CONV_NS / `CLK_PERIOD_NS)
`define SHIFT_LEN 16
`define PIN_CHAIN_SERIAL_IN 9
`define PIN_RESULT_SERIAL_OUT 10
`define PIN_SCLK 11
`define FIFO_DEPTH 2
`define WORD_RST 16'h0000
`endif

// ===== core/adc_pkg.sv
// types shared by the converter result interface
`include "adc_params.svh"
package adc_pkg;
  timeunit 1ns;
  timeprecision 100ps;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;
  // result pins: level driven and enable per pin
  typedef struct packed {
    logic [`WORD_W-1:0] dout;
    logic [`WORD_W-1:0] oe;
  } pins_t;
  // control inputs sampled from the pins
  typedef struct packed {
    logic interface_select;
    logic code_format_select;
    logic byte_order_swap;
    logic chip_select_n;
    logic read_enable_n;
    logic power_down_in;
    logic conversion_start_n;
    logic sclk;
    logic chain_serial_in;
  } ctl_t;
endpackage

// ===== core/sar_adc_result_interface.sv
// conversion control, result buffer and parallel/serial result output of the converter
`include "adc_params.svh"
module sar_adc_result_interface (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic interface_select,
  input wire logic code_format_select,
  input wire logic byte_order_swap,
  input wire logic chip_select_n,
  input wire logic read_enable_n,
  input wire logic power_down_in,
  input wire logic conversion_start_n,
  input wire logic [`WORD_W-1:0] sample_code,
  input wire logic [`WORD_W-1:0] data_in,
  output adc_pkg::pins_t result_pins,
  output logic busy,
  output logic stall
);
  timeunit 1ns;
  timeprecision 100ps;
  import adc_pkg::*;

  // code format and byte order of a result word
  function automatic logic [`WORD_W-1:0] fmt_word(input logic [`WORD_W-1:0] w,
                                                 input logic ob);
    fmt_word = {w[`WORD_W-1] ^ ~ob, w[`WORD_W-2:0]};
  endfunction

  function automatic logic [`WORD_W-1:0] swap_word(input logic [`WORD_W-1:0] w,
                                                  input logic sw);
    swap_word = sw ? {w[7:0], w[15:8]} : w;
  endfunction

  // chip select and read both low open the result outputs
  function automatic logic read_on(input ctl_t c);
    read_on = ~c.chip_select_n & ~c.read_enable_n;
  endfunction

  // two-flop synchronisers for every pin input, plus a third stage for edges
  // only the second stage feeds logic; the third is read for edges alone
  ctl_t raw;
  ctl_t s1_q;
  ctl_t s1_d;
  ctl_t s2_q;
  ctl_t s2_d;
  ctl_t s3_q;
  ctl_t s3_d;

  // gather the pin levels and chain the synchroniser stages
  always_comb begin
    raw.interface_select = interface_select;
    raw.code_format_select = code_format_select;
    raw.byte_order_swap = byte_order_swap;
    raw.chip_select_n = chip_select_n;
    raw.read_enable_n = read_enable_n;
    raw.power_down_in = power_down_in;
    raw.conversion_start_n = conversion_start_n;
    raw.sclk = data_in[`PIN_SCLK];
    raw.chain_serial_in = data_in[`PIN_CHAIN_SERIAL_IN];
    s1_d = raw;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // stages idle high, so no false start or clock edge follows reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  logic start_fall;
  logic sclk_rise;
  logic rd_active;
  logic rd_active_prev;
  // edge and read detection on the synchronised pins
  assign start_fall = s3_q.conversion_start_n & ~s2_q.conversion_start_n;
  assign sclk_rise = ~s3_q.sclk & s2_q.sclk & ~s2_q.chip_select_n;
  assign rd_active = read_on(s2_q);
  assign rd_active_prev = read_on(s3_q);

  // two-entry result buffer between conversion and output
  logic [`WORD_W-1:0] mem_q [`FIFO_DEPTH];
  logic [`WORD_W-1:0] mem_d [`FIFO_DEPTH];
  logic wptr_q;
  logic wptr_d;
  logic rptr_q;
  logic rptr_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic in_ready;
  logic out_valid;
  logic push;
  logic pop;
  logic [`WORD_W-1:0] push_word;

  // room for a new word, and a word waiting for the output stage
  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);

  // conversion sequencer: busy from start edge to end of conversion time
  conv_state_t st_q;
  conv_state_t st_d;
  logic [6:0] ccnt_q;
  logic [6:0] ccnt_d;
  logic busy_d;

  always_comb begin
    st_d = st_q;
    ccnt_d = ccnt_q;
    busy_d = busy;
    push = 1'b0;
    push_word = fmt_word(sample_code, s2_q.code_format_select);
    case (st_q)
      ST_IDLE: begin
        // start edge taken whatever chip select does, not while powered down
        if (start_fall && !s2_q.power_down_in && in_ready) begin
          st_d = ST_CONV;
          // conversion time is rounded down to whole clock cycles
          ccnt_d = 7'(`CONV_CYC - 1);
          busy_d = 1'b1;
        end
      end
      ST_CONV: begin
        // count the conversion time down, then hand the word to the buffer
        if (ccnt_q == 7'd0) begin
          st_d = ST_IDLE;
          busy_d = 1'b0;
          push = 1'b1;
        end else begin
          ccnt_d = ccnt_q - 7'd1;
        end
      end
      default: begin
        // illegal code: return to idle
        st_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  // sequencer registers; reset aborts a running conversion
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_IDLE;
      ccnt_q <= 7'd0;
      busy <= 1'b0;
    end else begin
      st_q <= st_d;
      ccnt_q <= ccnt_d;
      busy <= busy_d;
    end
  end

  // buffer pointers and storage
  always_comb begin
    mem_d = mem_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wptr_q] = push_word;
      wptr_d = ~wptr_q;
    end
    if (pop) begin
      rptr_d = ~rptr_q;
    end
    cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
  end

  // buffer registers; reset empties the buffer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_q[0] <= `WORD_RST;
      mem_q[1] <= `WORD_RST;
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      mem_q <= mem_d;
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
    end
  end

  // output stage: held word, serial shifter and pin drivers
  logic [`WORD_W-1:0] hold_q;
  logic [`WORD_W-1:0] hold_d;
  logic hold_v_q;
  logic hold_v_d;
  logic [`WORD_W-1:0] shreg_q;
  logic [`WORD_W-1:0] shreg_d;
  logic [4:0] bcnt_q;
  logic [4:0] bcnt_d;
  logic ser_bit_q;
  logic ser_bit_d;
  pins_t pins_d;
  logic stall_d;
  logic consumed;

  // hold keeps the shown word until the host has read it
  always_comb begin
    hold_d = hold_q;
    hold_v_d = hold_v_q;
    shreg_d = shreg_q;
    bcnt_d = bcnt_q;
    ser_bit_d = ser_bit_q;
    consumed = 1'b0;
    if (s2_q.interface_select) begin
      if (s2_q.chip_select_n) begin
        shreg_d = hold_q;
        bcnt_d = 5'd0;
      end else if (sclk_rise) begin
        // msb first; chain input enters behind the result word
        ser_bit_d = shreg_q[`WORD_W-1];
        shreg_d = {shreg_q[`WORD_W-2:0], s2_q.chain_serial_in};
        // the sixteenth rise finishes the word, so the next one may load
        if (bcnt_q == 5'(`SHIFT_LEN - 1)) begin
          consumed = hold_v_q;
        end
        if (bcnt_q != 5'(`SHIFT_LEN)) begin
          bcnt_d = bcnt_q + 5'd1;
        end
      end
    end else begin
      // a parallel read ends when chip select or read goes high
      consumed = rd_active_prev & ~rd_active & hold_v_q;
    end
    pop = out_valid & (~hold_v_q | consumed);
    if (consumed) begin
      hold_v_d = 1'b0;
    end
    if (pop) begin
      hold_d = mem_q[rptr_q];
      hold_v_d = 1'b1;
      // a word that arrives mid-frame waits for chip select high,
      // so a frame in progress is never torn
      if (s2_q.chip_select_n) begin
        shreg_d = mem_q[rptr_q];
      end
    end
    // a full buffer refuses new starts; stall tells the host why
    stall_d = ~in_ready;
    pins_d.dout = '0;
    pins_d.oe = '0;
    if (rd_active) begin
      if (s2_q.interface_select) begin
        // only the serial output pin is driven in serial mode
        pins_d.dout[`PIN_RESULT_SERIAL_OUT] = ser_bit_d;
        pins_d.oe[`PIN_RESULT_SERIAL_OUT] = 1'b1;
      end else begin
        // byte order follows the synchronised swap pin
        pins_d.dout = swap_word(hold_d, s2_q.byte_order_swap);
        pins_d.oe = '1;
      end
    end
  end

  // output registers; reset releases every result pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_q <= `WORD_RST;
      hold_v_q <= 1'b0;
      shreg_q <= `WORD_RST;
      bcnt_q <= 5'd0;
      ser_bit_q <= 1'b0;
      result_pins <= '0;
      stall <= 1'b0;
    end else begin
      hold_q <= hold_d;
      hold_v_q <= hold_v_d;
      shreg_q <= shreg_d;
      bcnt_q <= bcnt_d;
      ser_bit_q <= ser_bit_d;
      result_pins <= pins_d;
      stall <= stall_d;
    end
  end
endmodule // sar_adc_result_interface

// ===== verif/host_pins.sv
// host side of the result pins: resolves pin levels seen by the converter
`include "adc_params.svh"
module host_pins (
  input wire logic interface_select,
  input wire logic sclk,
  input wire logic chain_bit,
  input adc_pkg::pins_t result_pins,
  output logic [`WORD_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import adc_pkg::*;
  // released pins show the inverse of dout, which is zero, so they read high; host drives clock and chain bit in serial mode
  always_comb begin
    data_in = (result_pins.oe & result_pins.dout) | (~result_pins.oe & ~result_pins.dout);
    if (interface_select) begin
      data_in[`PIN_SCLK] = sclk;
      data_in[`PIN_CHAIN_SERIAL_IN] = chain_bit;
    end
  end
endmodule // host_pins

// ===== verif/sar_adc_result_interface_chk.sv
// checker of busy timing and pin enables of the result interface
module sar_adc_result_interface_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic interface_select,
  input wire logic chip_select_n,
  input wire logic read_enable_n,
  input wire logic power_down_in,
  input wire logic conversion_start_n,
  input adc_pkg::pins_t result_pins,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  import adc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // pin and busy relations
  property p_rst; disable iff (1'b0) rst |=> result_pins.oe == 16'h0000 && !busy; endproperty
  property p_dur; $rose(busy) |-> ##51 busy ##1 !busy; endproperty
  property p_cause; $rose(busy) |-> !$past(conversion_start_n, 3); endproperty
  property p_pd; power_down_in && $past(power_down_in, 4) |-> !$rose(busy); endproperty
  property p_ser;
    interface_select && $past(interface_select, 5) |-> (result_pins.oe & 16'hfbff) == 16'h0000;
  endproperty
  property p_cs;
    chip_select_n && $past(chip_select_n, 5) |-> result_pins.oe == 16'h0000;
  endproperty
  property p_rd;
    read_enable_n && $past(read_enable_n, 5) |-> result_pins.oe == 16'h0000;
  endproperty
  property p_par;
    !interface_select && !$past(interface_select, 5) && result_pins.oe != 16'h0000
      |-> result_pins.oe == 16'hffff;
  endproperty
  a_rst: assert property (p_rst) else $error("pins or busy not cleared by reset");
  a_dur: assert property (p_dur) else $error("busy width wrong");
  a_cause: assert property (p_cause) else $error("busy rose without start");
  a_pd: assert property (p_pd) else $error("start taken while powered down");
  a_ser: assert property (p_ser) else $error("unused pin driven in serial mode");
  a_cs: assert property (p_cs) else $error("pins driven without chip select");
  a_rd: assert property (p_rd) else $error("pins driven without read");
  a_par: assert property (p_par) else $error("parallel bus partly driven");
  c_conv: cover property ($rose(busy));
  c_par: cover property (result_pins.oe == 16'hffff);
  c_ser: cover property (result_pins.oe == 16'h0400);
endmodule // sar_adc_result_interface_chk
bind sar_adc_result_interface sar_adc_result_interface_chk chk (.clk_sys(clk_sys), .rst(rst),
  .interface_select(interface_select), .chip_select_n(chip_select_n),
  .read_enable_n(read_enable_n), .power_down_in(power_down_in),
  .conversion_start_n(conversion_start_n), .result_pins(result_pins), .busy(busy));

// ===== verif/test_sar_adc_result_interface.sv
// self-checking bench of the converter result interface
module test_sar_adc_result_interface;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_pkg::*;
  logic clk_sys = 0, rst = 1, sel = 0, fmt = 1, swap = 0, cs_n = 1, rd_n = 1, pd = 0, cnv_n = 1;
  logic sclk = 0, chain = 0, bit_exp;
  logic [15:0] code = 16'h0000, ser = 16'h25c3, chn = 16'h5a3c, data_in;
  pins_t pins;
  logic busy, stall;
  int fails = 0, checked = 0;
  // format, swap, sample, expected bus
  logic [33:0] rows [4] = '{{2'b10, 16'h1234, 16'h1234}, {2'b00, 16'h1234, 16'h9234},
    {2'b11, 16'h1234, 16'h3412}, {2'b01, 16'h1234, 16'h3492}};
  always #12.5 clk_sys = ~clk_sys;
  sar_adc_result_interface uut (.clk_sys(clk_sys), .rst(rst), .interface_select(sel),
    .code_format_select(fmt), .byte_order_swap(swap), .chip_select_n(cs_n),
    .read_enable_n(rd_n), .power_down_in(pd), .conversion_start_n(cnv_n),
    .sample_code(code), .data_in(data_in), .result_pins(pins), .busy(busy), .stall(stall));
  host_pins host (.interface_select(sel), .sclk(sclk), .chain_bit(chain), .result_pins(pins),
    .data_in(data_in));
  task check(input logic [15:0] e, input logic [15:0] s, input string n);
    checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task conv(input logic [15:0] s, input logic b);
    code = s;
    cnv_n = 0;
    tick(10);
    check({15'h0, b}, {15'h0, busy}, "busy in conversion");
    cnv_n = 1;
    tick(60);
  endtask
  task test_done;
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    test_done();
  end
  // main sequence
  initial begin
    tick(12);
    rst = 0;
    check(16'h0000, pins.oe, "oe after reset");
    tick(4);
    for (int i = 0; i < 4; i++) begin
      {fmt, swap} = rows[i][33:32];
      conv(rows[i][31:16], 1'b1);
      cs_n = 0;
      rd_n = 0;
      tick(6);
      check(16'hffff, pins.oe, "oe parallel");
      check(rows[i][15:0], pins.dout, "dout parallel");
      cs_n = 1;
      rd_n = 1;
      tick(6);
    end
    sel = 1;
    fmt = 0;
    tick(6);
    conv(16'ha5c3, 1'b1);
    cs_n = 0;
    rd_n = 0;
    tick(6);
    // one own word, then one word from a further converter on the chain input
    for (int k = 0; k < 32; k++) begin
      chain = k < 16 ? chn[15 - k] : 1'h0;
      sclk = 1;
      tick(4);
      sclk = 0;
      tick(4);
      bit_exp = k < 16 ? ser[15 - k] : chn[31 - k];
      check({15'h0, bit_exp}, {15'h0, pins.dout[10]}, "serial bit");
    end
    check(16'h0400, pins.oe, "oe serial");
    cs_n = 1;
    rd_n = 1;
    sel = 0;
    tick(6);
    pd = 1; // buffer already read out
    tick(6);
    conv(16'h0f0f, 1'b0);
    pd = 0;
    tick(6);
    code = 16'h7777;
    cnv_n = 0;
    tick(10);
    cnv_n = 1;
    tick(10);
    rst = 1;
    tick(2);
    check(16'h0000, pins.oe, "oe in reset");
    check(16'h0000, {14'h0, busy, stall}, "busy and stall in reset");
    rst = 0;
    tick(60);
    cs_n = 0;
    rd_n = 0;
    tick(6);
    check(16'h0000, pins.dout, "dout after abort");
    // buffer fills with chip select low and read high
    rd_n = 1;
    conv(16'h0101, 1'b1);
    conv(16'h0202, 1'b1);
    conv(16'h0303, 1'b1);
    check(16'h0001, {15'h0, stall}, "stall when full");
    conv(16'h0404, 1'b0);
    check(16'h0000, pins.oe, "oe with read high");
    test_done();
  end
endmodule // test_sar_adc_result_interface
